// ### hdl/cfv_map.svh
// constant map for the processor fault vectoring unit
`ifndef CFV_MAP_SVH
`define CFV_MAP_SVH
// vector offsets
`define CFV_VEC_NONE     20'h00000
`define CFV_VEC_RESET    20'h00100
`define CFV_VEC_CHECK    20'h00200
`define CFV_VEC_DATA     20'h00300
`define CFV_VEC_FETCH    20'h00400
// register index map on the plain port
`define CFV_REG_STATE    4'h0
`define CFV_REG_DFS      4'h1
`define CFV_REG_SAVE     4'h2
`define CFV_REG_VECTOR   4'h3
`define CFV_REG_STATUS   4'h4
// machine state bit positions (own layout)
`define CFV_MSR_CHKEN    0
`define CFV_MSR_RELOC    1
`define CFV_MSR_SUPER    2
// data fault status bit positions (own layout)
`define CFV_DFS_DIRECT   0
`define CFV_DFS_NOTFND   1
`define CFV_DFS_PROT     2
`define CFV_DFS_SEGTYPE  3
`define CFV_DFS_STORE    4
`define CFV_DFS_BRKPT    5
`define CFV_DFS_SEGMISS  6
`define CFV_DFS_EXTDIS   7
// reset values and the bench address step
`define CFV_MSR_RESET    8'h00
`define CFV_DFS_RESET    8'h00
`define CFV_WORD_ZERO    32'h00000000
`define CFV_ADDR_STEP    32'h00000004
`endif

// ### hdl/cfv_pkg.sv
// types shared by the fault vectoring unit
package cfv_pkg;
  typedef enum logic [2:0] {
    CFV_NONE,
    CFV_RESET,
    CFV_CHECK,
    CFV_DATA,
    CFV_FETCH
  } cfv_exc_t;
endpackage

// ### hdl/cfv_fault_vectoring.sv
// exception detection, vector selection and fault status for the core
// Operation
// [RQ1] soft or hard reset takes system reset at vector 00100.
// [RQ2] transfer error or check pin takes machine check at 00200.
// [RQ3] check source with check enable clear enters checkstop, no exception.
// [RQ4] any taken exception clears the check enable bit.
// [RQ5] bus or cache parity errors also raise machine check.
// [RQ6] memory controller reports parity or ECC errors via transfer error.
// [RQ7] machine check is imprecise; saved address need not name culprit.
// [RQ8] data fault goes to 00300 and records cause bits.
// [RQ9] direct-store cause bit set on direct-store access, else cleared.
// [RQ10] not-found bit set when no page group or block hit.
// [RQ11] protection bit set when page or block protection forbids access.
// [RQ12] segment type bit set for external/reservation access or write-through.
// [RQ13] direction bit set for store, cleared for load.
// [RQ14] breakpoint bit set on breakpoint match in any compare mode.
// [RQ15] segment miss bit set when segment search fails.
// [RQ16] external disabled bit set when external access is not enabled.
// [RQ17] fetch fault at 00400 when fetch address cannot translate.
// [RQ18] fetch from direct-store segment raises fetch fault.
// [RQ19] key and protect bits prohibiting read raise fetch fault.
// [RQ20] fetch from no-execute segment raises fetch fault.
// [RQ21] guarded fetch with fetch relocation on raises fetch fault.
// [RQ22] taking an exception saves state, enters supervisor, redirects.
// [RQ23] next sequential address is saved in the first save register.
// [RQ24] fault status updates only when a data fault is taken; here a software write to the register also updates it.
//
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/10ps
`include "cfv_map.svh"
module cfv_fault_vectoring (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        softResetIn,
  input  wire logic        hardResetIn,
  input  wire logic        busTransferErrorIn,
  input  wire logic        checkInputPinIn,
  input  wire logic        addrParityErr,
  input  wire logic        dataParityErr,
  input  wire logic        icacheParityErr,
  input  wire logic        dcacheParityErr,
  input  wire logic        dataAccess,
  input  wire logic        dataIsStore,
  input  wire logic        dataDirectStore,
  input  wire logic        dataNotFound,
  input  wire logic        dataProtViol,
  input  wire logic        dataExtCtrl,
  input  wire logic        dataReserve,
  input  wire logic        dataWriteThru,
  input  wire logic        dataSegTypeBit,
  input  wire logic        dataBreakMatch,
  input  wire logic        dataSegMiss,
  input  wire logic        extAccessEnable,
  input  wire logic        fetchValid,
  input  wire logic        fetchNoXlate,
  input  wire logic        fetchDirectStore,
  input  wire logic        fetchReadDenied,
  input  wire logic        fetchNoExecBit,
  input  wire logic        fetchGuarded,
  input  wire logic [31:0] nextInstrAddr,
  input  wire logic [3:0]  regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic [31:0]      regRdData,
  output logic             takeException,
  output logic [19:0]      vectorOffset,
  output logic             checkstop,
  output logic [31:0]      saveRestoreFirst
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  // three stages; a change counts once stages two and three agree
  logic [2:0] softSync_q;
  logic [2:0] hardSync_q;
  logic [2:0] teaSync_q;
  logic [2:0] pinSync_q;
  logic       softLvl_q;
  logic       hardLvl_q;
  logic       teaLvl_q;
  logic       pinLvl_q;

  always_ff @(posedge clock) begin
    if (reset) begin
      softSync_q <= 3'h0;
      hardSync_q <= 3'h0;
      teaSync_q  <= 3'h0;
      pinSync_q  <= 3'h0;
    end else begin
      softSync_q <= {softSync_q[1:0], softResetIn};
      hardSync_q <= {hardSync_q[1:0], hardResetIn};
      teaSync_q  <= {teaSync_q[1:0], busTransferErrorIn};
      pinSync_q  <= {pinSync_q[1:0], checkInputPinIn};
    end
  end

  // filtered levels hold until both late stages agree
  always_ff @(posedge clock) begin
    if (reset) begin
      softLvl_q <= 1'b0;
      hardLvl_q <= 1'b0;
      teaLvl_q  <= 1'b0;
      pinLvl_q  <= 1'b0;
    end else begin
      if (softSync_q[2] == softSync_q[1]) softLvl_q <= softSync_q[2];
      if (hardSync_q[2] == hardSync_q[1]) hardLvl_q <= hardSync_q[2];
      if (teaSync_q[2] == teaSync_q[1])   teaLvl_q  <= teaSync_q[2];
      if (pinSync_q[2] == pinSync_q[1])   pinLvl_q  <= pinSync_q[2];
    end
  end

  // ---------------------------------------------------------------
  // cause detection
  // ---------------------------------------------------------------
  logic [7:0]  machineState_q;
  logic [7:0]  dataFaultStatus_q;
  logic        checkstop_q;
  logic        softPrev_q;
  logic        hardPrev_q;
  logic        checkPrev_q;

  wire checkEnable = machineState_q[`CFV_MSR_CHKEN];
  wire fetchReloc  = machineState_q[`CFV_MSR_RELOC];
  // [RQ1] reset edge detect
  wire resetRise   = (softLvl_q & ~softPrev_q) | (hardLvl_q & ~hardPrev_q);
  // [RQ2] [RQ5] check sources, parity included
  wire checkSrc    = teaLvl_q | pinLvl_q | addrParityErr | dataParityErr |
                     icacheParityErr | dcacheParityErr;
  wire checkRise   = checkSrc & ~checkPrev_q;
  // [RQ3] disabled check stops the core
  wire checkTake   = checkRise & checkEnable;
  wire stopNow     = checkRise & ~checkEnable;

  // [RQ10] [RQ11] [RQ12] [RQ15] [RQ16] data cause terms
  wire extDisabled = dataExtCtrl & ~extAccessEnable;
  wire segTypeHit  = ((dataExtCtrl | dataReserve) & dataSegTypeBit) |
                     (dataExtCtrl & dataWriteThru);
  wire dataCause   = dataDirectStore | dataNotFound | dataProtViol |
                     segTypeHit | dataBreakMatch | dataSegMiss | extDisabled;
  wire dataTake    = dataAccess & dataCause;
  // [RQ17] [RQ18] [RQ19] [RQ20] [RQ21] fetch cause terms
  wire fetchCause  = fetchNoXlate | fetchDirectStore | fetchReadDenied |
                     fetchNoExecBit | (fetchGuarded & fetchReloc);
  wire fetchTake   = fetchValid & fetchCause;

  // priority: reset, machine check, data, fetch; only reset while stopped
  wire takeReset   = resetRise;
  wire takeCheck   = ~takeReset & checkTake & ~checkstop_q;
  wire takeData    = ~takeReset & ~checkRise & dataTake & ~checkstop_q;
  wire takeFetch   = ~takeReset & ~checkRise & ~dataTake & fetchTake &
                     ~checkstop_q;
  wire anyTake     = takeReset | takeCheck | takeData | takeFetch;

  cfv_pkg::cfv_exc_t excSel;
  assign excSel = takeReset ? cfv_pkg::CFV_RESET :
                  takeCheck ? cfv_pkg::CFV_CHECK :
                  takeData  ? cfv_pkg::CFV_DATA  :
                  takeFetch ? cfv_pkg::CFV_FETCH : cfv_pkg::CFV_NONE;

  // [RQ8] [RQ17] fixed vector per exception
  logic [19:0] vecSel;
  always_comb begin
    case (excSel)
      cfv_pkg::CFV_RESET: vecSel = `CFV_VEC_RESET;
      cfv_pkg::CFV_CHECK: vecSel = `CFV_VEC_CHECK;
      cfv_pkg::CFV_DATA:  vecSel = `CFV_VEC_DATA;
      cfv_pkg::CFV_FETCH: vecSel = `CFV_VEC_FETCH;
      default:            vecSel = `CFV_VEC_NONE;
    endcase
  end

  // [RQ9] [RQ13] [RQ14] full status word, each bit set or cleared
  logic [7:0] dfsNew;
  always_comb begin
    dfsNew                   = `CFV_DFS_RESET;
    dfsNew[`CFV_DFS_DIRECT]  = dataDirectStore;
    dfsNew[`CFV_DFS_NOTFND]  = dataNotFound;
    dfsNew[`CFV_DFS_PROT]    = dataProtViol;
    dfsNew[`CFV_DFS_SEGTYPE] = segTypeHit;
    dfsNew[`CFV_DFS_STORE]   = dataIsStore;
    dfsNew[`CFV_DFS_BRKPT]   = dataBreakMatch;
    dfsNew[`CFV_DFS_SEGMISS] = dataSegMiss;
    dfsNew[`CFV_DFS_EXTDIS]  = extDisabled;
  end

  // register writes by software
  wire wrState = regWrite & (regAddr == `CFV_REG_STATE);
  wire wrDfs   = regWrite & (regAddr == `CFV_REG_DFS);
  wire wrSave  = regWrite & (regAddr == `CFV_REG_SAVE);

  // ---------------------------------------------------------------
  // state registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      softPrev_q  <= 1'b0;
      hardPrev_q  <= 1'b0;
      checkPrev_q <= 1'b0;
    end else begin
      softPrev_q  <= softLvl_q;
      hardPrev_q  <= hardLvl_q;
      checkPrev_q <= checkSrc;
    end
  end

  // exception entry wins over a software write in the same cycle
  always_ff @(posedge clock) begin
    if (reset) begin
      machineState_q <= `CFV_MSR_RESET;
    end else if (anyTake) begin
      // [RQ4] [RQ22] clear check enable, enter supervisor
      machineState_q[`CFV_MSR_CHKEN] <= 1'b0;
      machineState_q[`CFV_MSR_SUPER] <= 1'b1;
      machineState_q[`CFV_MSR_RELOC] <= 1'b0;
    end else if (wrState) begin
      machineState_q <= regWrData[7:0];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      dataFaultStatus_q <= `CFV_DFS_RESET;
    end else if (takeData) begin
      // [RQ24] all cause bits together, only on a taken data fault
      dataFaultStatus_q <= dfsNew;
    end else if (wrDfs) begin
      dataFaultStatus_q <= regWrData[7:0];
    end
  end

  // [RQ3] checkstop holds until reset or system reset
  always_ff @(posedge clock) begin
    if (reset) begin
      checkstop_q <= 1'b0;
    end else if (takeReset) begin
      checkstop_q <= 1'b0;
    end else if (stopNow) begin
      checkstop_q <= 1'b1;
    end
  end

  // [RQ23] [RQ7] save next sequential address, machine check too
  always_ff @(posedge clock) begin
    if (reset) begin
      saveRestoreFirst <= `CFV_WORD_ZERO;
    end else if (anyTake) begin
      saveRestoreFirst <= nextInstrAddr;
    end else if (wrSave) begin
      saveRestoreFirst <= regWrData;
    end
  end

  // [RQ22] redirect pulse with its vector
  always_ff @(posedge clock) begin
    if (reset) begin
      takeException <= 1'b0;
      vectorOffset  <= `CFV_VEC_NONE;
    end else begin
      takeException <= anyTake;
      vectorOffset  <= anyTake ? vecSel : vectorOffset;
    end
  end

  assign checkstop = checkstop_q;

  // ---------------------------------------------------------------
  // register read port
  // ---------------------------------------------------------------
  // unmapped indices read zero; read data lives one cycle only
  wire [31:0] rdMux =
    (regAddr == `CFV_REG_STATE)  ? {24'h000000, machineState_q} :
    (regAddr == `CFV_REG_DFS)    ? {24'h000000, dataFaultStatus_q} :
    (regAddr == `CFV_REG_SAVE)   ? saveRestoreFirst :
    (regAddr == `CFV_REG_VECTOR) ? {12'h000, vectorOffset} :
    (regAddr == `CFV_REG_STATUS) ? {31'h00000000, checkstop_q} :
                                   `CFV_WORD_ZERO;

  always_ff @(posedge clock) begin
    if (reset) begin
      regRdData <= `CFV_WORD_ZERO;
    end else begin
      regRdData <= regRead ? rdMux : `CFV_WORD_ZERO;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  reset_vector_a: assert property ( // [RQ1]
    resetRise |=> takeException && vectorOffset == `CFV_VEC_RESET)
    else $error("system reset not vectored to 00100");
  check_vector_a: assert property ( // [RQ2]
    takeCheck |=> takeException && vectorOffset == `CFV_VEC_CHECK)
    else $error("machine check not vectored to 00200");
  check_stop_a: assert property ( // [RQ3]
    (stopNow && !resetRise) |=> checkstop && !takeException)
    else $error("disabled check did not stop the core");
  enable_clear_a: assert property ( // [RQ4]
    anyTake |=> !machineState_q[`CFV_MSR_CHKEN])
    else $error("check enable not cleared on exception");
  parity_check_a: assert property ( // [RQ5]
    (checkEnable && !checkstop && !checkPrev_q && !resetRise &&
     dcacheParityErr) |=> vectorOffset == `CFV_VEC_CHECK)
    else $error("parity error did not raise machine check");
  data_vector_a: assert property ( // [RQ8]
    takeData |=> takeException && vectorOffset == `CFV_VEC_DATA)
    else $error("data fault not vectored to 00300");
  store_bit_a: assert property ( // [RQ13]
    takeData |=> dataFaultStatus_q[`CFV_DFS_STORE] == $past(dataIsStore))
    else $error("direction bit wrong");
  fetch_vector_a: assert property ( // [RQ17]
    takeFetch |=> takeException && vectorOffset == `CFV_VEC_FETCH)
    else $error("fetch fault not vectored to 00400");
  save_addr_a: assert property ( // [RQ23]
    anyTake |=> saveRestoreFirst == $past(nextInstrAddr))
    else $error("next address not saved");
  status_hold_a: assert property ( // [RQ24]
    (!takeData && !wrDfs) |=> $stable(dataFaultStatus_q))
    else $error("fault status changed without a data fault");
  supervisor_set_a: assert property ( // [RQ22]
    anyTake |=> machineState_q[`CFV_MSR_SUPER])
    else $error("supervisor bit not set on exception");
  stopped_quiet_a: assert property ( // [RQ3]
    (checkstop && !resetRise) |=> !takeException)
    else $error("exception taken while stopped");
  direct_bit_a: assert property ( // [RQ9]
    takeData |=> dataFaultStatus_q[`CFV_DFS_DIRECT] == $past(dataDirectStore))
    else $error("direct-store bit wrong");
  notfound_bit_a: assert property ( // [RQ10]
    takeData |=> dataFaultStatus_q[`CFV_DFS_NOTFND] == $past(dataNotFound))
    else $error("not-found bit wrong");
  extdis_bit_a: assert property ( // [RQ16]
    takeData |=> dataFaultStatus_q[`CFV_DFS_EXTDIS] ==
                 ($past(dataExtCtrl) && !$past(extAccessEnable)))
    else $error("external disabled bit wrong");

  reset_seen_c: cover property (resetRise ##1 takeException);
  check_taken_c: cover property (takeCheck ##1 takeException);
  stop_entered_c: cover property (stopNow ##1 checkstop);
  data_taken_c: cover property (takeData ##1 takeException);
  fetch_taken_c: cover property (takeFetch ##1 takeException);

endmodule

// ### bench/cfv_far_end.sv
// model of the memory controller and the reset and check pin sources
`timescale 1ns/10ps
module cfv_far_end #(
  parameter int HOLD = 6
) (
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       accessReq,
  input  wire logic       memFault,
  input  wire logic [2:0] pinReq,
  output logic            softResetIn,
  output logic            hardResetIn,
  output logic            checkInputPinIn,
  output logic            busTransferErrorIn
);
  // --------------------
  // request decode
  // --------------------
  logic [3:0] lineQ;
  logic [3:0] lineD;
  logic [7:0] holdQ;
  logic       startW;
  assign startW = (accessReq & memFault) | (|pinReq);
  assign lineD  = {accessReq & memFault, pinReq};
  // --------------------
  // line hold
  // --------------------
  // lines stay up several cycles so the pin filter sees a steady level
  always_ff @(posedge clock) begin
    if (reset) begin
      lineQ <= 4'h0;
      holdQ <= 8'h00;
    end else if (startW) begin
      lineQ <= lineD;
      holdQ <= 8'(HOLD);
    end else if (holdQ != 8'h00) begin
      holdQ <= holdQ - 8'h01;
    end else begin
      lineQ <= 4'h0;
    end
  end
  assign softResetIn        = lineQ[0];
  assign hardResetIn        = lineQ[1];
  assign checkInputPinIn    = lineQ[2];
  assign busTransferErrorIn = lineQ[3];
endmodule

// ### bench/cpu_fault_vectoring_tb.sv
// self-checking bench for the processor fault vectoring unit
`timescale 1ns/10ps
`include "cfv_map.svh"
module cpu_fault_vectoring_tb;
  typedef struct packed {
    logic [10:0] cause;
    logic [7:0]  dfs;
  } cfv_row_t;
  // --------------------
  // signals
  // --------------------
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic        softResetIn, hardResetIn, busTransferErrorIn;
  logic        checkInputPinIn, accessReq, memFault;
  logic [2:0]  pinReq;
  logic [3:0]  parity;
  logic        dataAccess, dataIsStore, dataDirectStore, dataNotFound;
  logic        dataProtViol, dataExtCtrl, dataReserve, dataWriteThru;
  logic        dataSegTypeBit, dataBreakMatch, dataSegMiss;
  logic        extAccessEnable, fetchValid, fetchNoXlate;
  logic        fetchDirectStore, fetchReadDenied, fetchNoExecBit;
  logic        fetchGuarded, regWrite, regRead, takeException, checkstop;
  logic [31:0] nextInstrAddr, regWrData, regRdData, saveRestoreFirst;
  logic [31:0] addr;
  logic [3:0]  regAddr;
  logic [19:0] vectorOffset;
  int          fails, n_tests, cnt;
  // cause order: store direct notfound prot extctl reserve
  // writethru segtype brkpt segmiss extenable
  cfv_row_t    rows [9] = '{'{11'h501, 8'h12}, '{11'h201, 8'h01},
    '{11'h081, 8'h04}, '{11'h029, 8'h08}, '{11'h051, 8'h08},
    '{11'h405, 8'h30}, '{11'h003, 8'h40}, '{11'h040, 8'h80},
    '{11'h048, 8'h88}};

  always #10 clock = ~clock;

  cfv_far_end farEnd (
    .clock, .reset, .accessReq, .memFault, .pinReq, .softResetIn,
    .hardResetIn, .checkInputPinIn, .busTransferErrorIn
  );
  cfv_fault_vectoring DUT (
    .clock, .reset, .softResetIn, .hardResetIn, .busTransferErrorIn,
    .checkInputPinIn, .addrParityErr(parity[0]), .dataParityErr(parity[1]),
    .icacheParityErr(parity[2]), .dcacheParityErr(parity[3]), .dataAccess,
    .dataIsStore, .dataDirectStore, .dataNotFound, .dataProtViol,
    .dataExtCtrl, .dataReserve, .dataWriteThru, .dataSegTypeBit,
    .dataBreakMatch, .dataSegMiss, .extAccessEnable, .fetchValid,
    .fetchNoXlate, .fetchDirectStore, .fetchReadDenied, .fetchNoExecBit,
    .fetchGuarded, .nextInstrAddr, .regAddr, .regWrData, .regWrite,
    .regRead, .regRdData, .takeException, .vectorOffset, .checkstop,
    .saveRestoreFirst
  );
  // --------------------
  // tasks
  // --------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1;
    chk(regRdData, e);
  endtask
  // one qualified cycle of data and/or fetch causes
  task pulse(input logic [10:0] d, input logic dv, input logic [4:0] f,
             input logic fv, input logic [31:0] a);
    @(posedge clock);
    {dataIsStore, dataDirectStore, dataNotFound, dataProtViol, dataExtCtrl,
     dataReserve, dataWriteThru, dataSegTypeBit, dataBreakMatch,
     dataSegMiss, extAccessEnable} <= d;
    {fetchNoXlate, fetchDirectStore, fetchReadDenied, fetchNoExecBit,
     fetchGuarded} <= f;
    dataAccess <= dv;
    fetchValid <= fv;
    nextInstrAddr <= a;
    @(posedge clock);
    dataAccess <= 1'b0;
    fetchValid <= 1'b0;
    #1;
  endtask
  // sources: 0 check pin, 1 transfer error, 2..5 parity, 6 soft, 7 hard
  task src(input int s);
    @(posedge clock);
    pinReq <= (s == 0) ? 3'h4 : (s == 6) ? 3'h1 : (s == 7) ? 3'h2 : 3'h0;
    accessReq <= (s == 1);
    memFault <= (s == 1);
    parity <= (s > 1 && s < 6) ? 4'h1 << (s - 2) : 4'h0;
    @(posedge clock);
    pinReq <= 3'h0;
    accessReq <= 1'b0;
    memFault <= 1'b0;
    parity <= 4'h0;
  endtask
  // pins pass a synchroniser, so count pulses over a generous span
  task wait_exc(output int n);
    n = 0;
    repeat (24) begin
      #1;
      if (takeException === 1'b1) n++;
      @(posedge clock);
    end
    #1;
  endtask
  task tally_and_finish();
    if (fails == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // --------------------
  // sequence
  // --------------------
  initial begin
    {dataAccess, dataIsStore, dataDirectStore, dataNotFound, dataProtViol,
     dataExtCtrl, dataReserve, dataWriteThru, dataSegTypeBit, dataBreakMatch,
     dataSegMiss, extAccessEnable, fetchValid, fetchNoXlate, fetchDirectStore,
     fetchReadDenied, fetchNoExecBit, fetchGuarded, regWrite, regRead,
     accessReq, memFault} = '0;
    pinReq = 3'h0;
    parity = 4'h0;
    regAddr = 4'h0;
    regWrData = 32'h00000000;
    addr = 32'h00001000;
    nextInstrAddr = addr;
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    #1;
    chk({takeException, checkstop, vectorOffset}, 32'h0);
    rd(`CFV_REG_STATE, 32'h0);
    rd(`CFV_REG_DFS, 32'h0);
    rd(4'h5, 32'h0);
    for (int i = 0; i < 9; i++) begin
      addr = addr + `CFV_ADDR_STEP;
      pulse(rows[i].cause, 1'b1, 5'h00, 1'b0, addr);
      chk(takeException, 32'h1);
      chk(vectorOffset, `CFV_VEC_DATA);
      chk(saveRestoreFirst, addr);
      rd(`CFV_REG_DFS, rows[i].dfs);
    end
    rd(`CFV_REG_STATE, 32'h4);
    for (int k = 0; k < 5; k++) begin
      if (k == 4) wr(`CFV_REG_STATE, 32'h2);
      addr = addr + `CFV_ADDR_STEP;
      pulse(11'h001, 1'b0, 5'h10 >> k, 1'b1, addr);
      chk(takeException, 32'h1);
      chk(vectorOffset, `CFV_VEC_FETCH);
      chk(saveRestoreFirst, addr);
    end
    rd(`CFV_REG_STATE, 32'h4);
    pulse(11'h001, 1'b0, 5'h01, 1'b1, addr);
    chk(takeException, 32'h0);
    pulse(11'h201, 1'b1, 5'h10, 1'b1, addr);
    chk(vectorOffset, `CFV_VEC_DATA);
    pulse(11'h001, 1'b1, 5'h00, 1'b0, addr);
    chk(takeException, 32'h0);
    rd(`CFV_REG_DFS, 32'h1);
    for (int s = 0; s < 6; s++) begin
      wr(`CFV_REG_STATE, 32'h1);
      src(s);
      wait_exc(cnt);
      chk(cnt, 32'h1);
      chk(vectorOffset, `CFV_VEC_CHECK);
      rd(`CFV_REG_STATE, 32'h4);
    end
    rd(`CFV_REG_DFS, 32'h1);
    src(0);
    wait_exc(cnt);
    chk(cnt, 32'h0);
    chk(checkstop, 32'h1);
    rd(`CFV_REG_STATUS, 32'h1);
    pulse(11'h201, 1'b1, 5'h00, 1'b0, addr);
    chk(takeException, 32'h0);
    for (int r = 6; r < 8; r++) begin
      src(r);
      wait_exc(cnt);
      chk(cnt, 32'h1);
      chk(vectorOffset, `CFV_VEC_RESET);
      chk(checkstop, 32'h0);
    end
    rd(`CFV_REG_VECTOR, {12'h000, `CFV_VEC_RESET});
    // software paths of the save and data fault status registers
    wr(`CFV_REG_SAVE, 32'h0000ABC0);
    rd(`CFV_REG_SAVE, 32'h0000ABC0);
    wr(`CFV_REG_DFS, 32'h000000A5);
    rd(`CFV_REG_DFS, 32'h000000A5);
    // mid-run reset must bring every output and register back to zero
    @(posedge clock);
    reset <= 1'b1;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    #1;
    chk({takeException, checkstop, vectorOffset}, 32'h0);
    rd(`CFV_REG_STATE, 32'h0);
    rd(`CFV_REG_SAVE, 32'h0);
    rd(`CFV_REG_DFS, 32'h0);
    rd(`CFV_REG_STATUS, 32'h0);
    tally_and_finish();
  end
  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clock);
    fails++;
    tally_and_finish();
  end
endmodule
